// >>> include/rtc_trim_pkg.sv
/*
 * constants and carrier types for the trimmed second counter:
 * register offsets, field positions, reset values and counts.
 * assumes a 32-bit apb with byte addresses and one word per register.
 */
`default_nettype none

package rtc_trim_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_LOCK_KEY   = 8'h00;
    localparam logic [7:0] OFS_TRIM_CTRL  = 8'h04;
    localparam logic [7:0] OFS_TRIM_VALUE = 8'h08;
    localparam logic [7:0] OFS_CNT_CTRL   = 8'h0c;
    localparam logic [7:0] OFS_SECONDS    = 8'h10;
    localparam logic [7:0] OFS_PRESCALE   = 8'h14;

    // reset values
    localparam logic [7:0] LOCK_KEY_OPEN  = 8'hc1;
    localparam logic [7:0] RST_TRIM_CTRL  = 8'h00;
    localparam logic [8:0] RST_TRIM_VALUE = 9'h000;

    // field positions
    localparam int TRIM_EN_BIT    = 0;
    localparam int PERIOD_LSB     = 1;
    localparam int PERIOD_MSB     = 3;
    localparam int TRIM_VAL_MSB   = 8;
    localparam int CNT_RESET_BIT  = 0;
    localparam int IRQ_EN_BIT     = 1;

    // reference period codes
    localparam logic [2:0] PERIOD_1S  = 3'h0;
    localparam logic [2:0] PERIOD_10S = 3'h1;
    localparam logic [2:0] PERIOD_20S = 3'h2;
    localparam logic [2:0] PERIOD_30S = 3'h3;
    localparam logic [2:0] PERIOD_60S = 3'h4;

    // seconds in each reference period
    localparam logic [5:0] SECS_1  = 6'h01;
    localparam logic [5:0] SECS_10 = 6'h0a;
    localparam logic [5:0] SECS_20 = 6'h14;
    localparam logic [5:0] SECS_30 = 6'h1e;
    localparam logic [5:0] SECS_60 = 6'h3c;

    // low-speed clock rate and counts per nominal second
    localparam int          LOW_SPEED_HZ  = 32768;
    localparam logic [15:0] NOMINAL_COUNT = 16'(LOW_SPEED_HZ);

    // whole state of the counter block
    typedef struct packed {
        logic        ls_s1;
        logic        ls_s2;
        logic        ls_s3;
        logic [7:0]  lock_key;
        logic        trim_enable;
        logic [2:0]  period_sel;
        logic [8:0]  trim_value;
        logic        act_enable;
        logic [2:0]  act_sel;
        logic [8:0]  act_value;
        logic [15:0] presc;
        logic [5:0]  sec_in_period;
        logic [31:0] seconds;
        logic        rst_pend;
        logic        irq_en;
        logic        restart_armed;
        logic        tick;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rtc_state_t;

endpackage : rtc_trim_pkg

`default_nettype wire

// >>> hdl/rtc_second_counter_trim.sv
/*
 * trimmed second counter: divides the low-speed clock down to a 1 hz
 * tick, stretches or shortens one second per reference period, and
 * offers its registers on an apb slave port.
 * assumes the low-speed clock arrives as a plain pin, far slower than
 * i_core_clk, and that apb is driven from i_core_clk.
 */
// Summary of operation
// - lock key resets open; others block trim writes
// - period field picks 1,10,20,30,60 second period
// - bit zero enables trim; upper bits zero
// - nine-bit signed trim value, upper bits zero
// - positive lengthens, negative shortens the second
// - zero trim value leaves second length unchanged
// - counter derives 1 hz tick from low-speed clock
// - interrupt pulses with each second count-up
// - first interrupt one second after enable following a counter reset
// - plain second is 32768 low-speed periods
// - trimmed length applies to one second per period
`timescale 1ns/1ns
`default_nettype none

module rtc_second_counter_trim #(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_low_speed_clock,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic [31:0]            o_prdata,
    output logic                   o_tick_1hz,
    output logic                   o_irq_1hz
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    rtc_trim_pkg::rtc_state_t q;
    rtc_trim_pkg::rtc_state_t d;

    logic        ls_edge;
    logic        setup_phase;
    logic        access_wr;
    logic        unlocked;
    logic        addr_mapped;
    logic [7:0]  addr_lo;
    logic [31:0] read_word;
    logic [5:0]  period_secs;
    logic [16:0] trimmed_len;
    logic [15:0] second_len;
    logic        last_count;

    ////////////////////////////////////////////////////////////////////
    // combinational helpers

    // low byte of the address selects the register
    assign addr_lo = 8'(i_paddr);

    // edge taken from the second stage and its history, never the first
    assign ls_edge = q.ls_s2 & ~q.ls_s3;

    // apb phases; the write lands at the completing access edge
    assign setup_phase = i_psel & ~i_penable;
    assign access_wr   = i_psel & i_penable & q.pready & i_pwrite
                         & ~q.pslverr;

    // trim registers open only while the key holds its open value
    assign unlocked = (q.lock_key == rtc_trim_pkg::LOCK_KEY_OPEN);

    // seconds in the active reference period
    always_comb begin
        case (q.act_sel)
            rtc_trim_pkg::PERIOD_1S:  period_secs = rtc_trim_pkg::SECS_1;
            rtc_trim_pkg::PERIOD_10S: period_secs = rtc_trim_pkg::SECS_10;
            rtc_trim_pkg::PERIOD_20S: period_secs = rtc_trim_pkg::SECS_20;
            rtc_trim_pkg::PERIOD_30S: period_secs = rtc_trim_pkg::SECS_30;
            rtc_trim_pkg::PERIOD_60S: period_secs = rtc_trim_pkg::SECS_60;
            // reserved codes fall back to a one second period
            default:                  period_secs = rtc_trim_pkg::SECS_1;
        endcase
    end

    // nominal plus sign-extended trim; zero trim adds nothing
    assign trimmed_len = {1'b0, rtc_trim_pkg::NOMINAL_COUNT}
                         + {{8{q.act_value[8]}}, q.act_value};

    // only the first second of each period is trimmed
    assign second_len = (q.act_enable && q.sec_in_period == 6'h00)
                        ? trimmed_len[15:0]
                        : rtc_trim_pkg::NOMINAL_COUNT;

    assign last_count = (q.presc == 16'(second_len - 16'h0001));

    // read mux; unused bits read as zero
    always_comb begin
        addr_mapped = 1'b1;
        read_word   = 32'h0000_0000;
        case (addr_lo)
            rtc_trim_pkg::OFS_LOCK_KEY: begin
                read_word[7:0] = q.lock_key;
            end
            rtc_trim_pkg::OFS_TRIM_CTRL: begin
                read_word[rtc_trim_pkg::TRIM_EN_BIT] = q.trim_enable;
                read_word[rtc_trim_pkg::PERIOD_MSB:rtc_trim_pkg::PERIOD_LSB]
                    = q.period_sel;
            end
            rtc_trim_pkg::OFS_TRIM_VALUE: begin
                read_word[rtc_trim_pkg::TRIM_VAL_MSB:0] = q.trim_value;
            end
            rtc_trim_pkg::OFS_CNT_CTRL: begin
                read_word[rtc_trim_pkg::CNT_RESET_BIT] = q.rst_pend;
                read_word[rtc_trim_pkg::IRQ_EN_BIT]    = q.irq_en;
            end
            rtc_trim_pkg::OFS_SECONDS: begin
                read_word = q.seconds;
            end
            rtc_trim_pkg::OFS_PRESCALE: begin
                read_word[15:0]  = q.presc;
                read_word[21:16] = q.sec_in_period;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next-state logic

    // counter first, bus writes after so a software set wins a clear
    always_comb begin
        d = q;

        // two-stage pin synchroniser plus edge history
        d.ls_s1 = i_low_speed_clock;
        d.ls_s2 = q.ls_s1;
        d.ls_s3 = q.ls_s2;

        d.tick = 1'b0;
        d.irq  = 1'b0;

        // low-speed edge advances the divider
        if (ls_edge) begin
            if (q.rst_pend) begin
                // counter reset: restart second and period, relatch trim
                d.presc         = 16'h0000;
                d.sec_in_period = 6'h00;
                d.rst_pend      = 1'b0;
                d.restart_armed = 1'b1;
                d.act_enable    = q.trim_enable;
                d.act_sel       = q.period_sel;
                d.act_value     = q.trim_value;
            end else if (last_count) begin
                d.presc   = 16'h0000;
                d.tick    = 1'b1;
                d.irq     = q.irq_en;
                d.seconds = q.seconds + 32'h0000_0001;
                d.restart_armed = 1'b0;
                if (q.sec_in_period >= 6'(period_secs - 6'h01)) begin
                    d.sec_in_period = 6'h00;
                end else begin
                    d.sec_in_period = q.sec_in_period + 6'h01;
                end
                // settings change only between seconds, never mid-count
                d.act_enable = q.trim_enable;
                d.act_sel    = q.period_sel;
                d.act_value  = q.trim_value;
            end else begin
                d.presc = q.presc + 16'h0001;
            end
        end

        // apb answer registered at setup, seen during access
        d.pready  = setup_phase;
        d.pslverr = setup_phase & ~addr_mapped;
        if (setup_phase) begin
            d.prdata = read_word;
        end

        // register writes
        if (access_wr) begin
            case (addr_lo)
                rtc_trim_pkg::OFS_LOCK_KEY: begin
                    d.lock_key = i_pwdata[7:0];
                end
                rtc_trim_pkg::OFS_TRIM_CTRL: begin
                    // a locked write is dropped with no error
                    if (unlocked) begin
                        d.trim_enable =
                            i_pwdata[rtc_trim_pkg::TRIM_EN_BIT];
                        d.period_sel = i_pwdata[rtc_trim_pkg::PERIOD_MSB:
                                                rtc_trim_pkg::PERIOD_LSB];
                    end
                end
                rtc_trim_pkg::OFS_TRIM_VALUE: begin
                    if (unlocked) begin
                        d.trim_value =
                            i_pwdata[rtc_trim_pkg::TRIM_VAL_MSB:0];
                    end
                end
                rtc_trim_pkg::OFS_CNT_CTRL: begin
                    if (i_pwdata[rtc_trim_pkg::CNT_RESET_BIT]) begin
                        d.rst_pend = 1'b1;
                    end
                    d.irq_en = i_pwdata[rtc_trim_pkg::IRQ_EN_BIT];
                    // enable after a counter reset starts a fresh second
                    if (i_pwdata[rtc_trim_pkg::IRQ_EN_BIT] && !q.irq_en
                        && q.restart_armed) begin
                        d.presc         = 16'h0000;
                        d.sec_in_period = 6'h00;
                        d.restart_armed = 1'b0;
                        d.tick          = 1'b0;
                        d.irq           = 1'b0;
                    end
                end
                default: begin
                    // read-only or unmapped: nothing stored
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q               <= '0;
            q.lock_key      <= rtc_trim_pkg::LOCK_KEY_OPEN;
            q.trim_enable   <= rtc_trim_pkg::RST_TRIM_CTRL[0];
            q.period_sel    <= rtc_trim_pkg::RST_TRIM_CTRL[3:1];
            q.trim_value    <= rtc_trim_pkg::RST_TRIM_VALUE;
            q.act_value     <= rtc_trim_pkg::RST_TRIM_VALUE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops

    assign o_pready   = q.pready;
    assign o_pslverr  = q.pslverr;
    assign o_prdata   = q.prdata;
    assign o_tick_1hz = q.tick;
    assign o_irq_1hz  = q.irq;

endmodule : rtc_second_counter_trim

`default_nettype wire

// >>> sim/rtc_trim_props.sv
/*
 * port checker for the trimmed second counter.
 * assumes it is bound onto rtc_second_counter_trim, one core clock.
 */
`timescale 1ns/1ns
`default_nettype none

module rtc_trim_props #(
    parameter int ADDR_W = 8
) (
    input wire logic              i_core_clk,
    input wire logic              i_rst_b,
    input wire logic              i_low_speed_clock,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    input wire logic [31:0]       o_prdata,
    input wire logic              o_tick_1hz,
    input wire logic              o_irq_1hz
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    wire logic setup;
    wire logic rd;
    // setup phase and read answer, shared by the apb checks
    assign setup = i_psel && !i_penable;
    assign rd = o_pready && !i_pwrite;

    ////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (setup |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property
        (o_pready |-> $past(setup) && i_penable ##1 !o_pready)
        else $error("ready not a single access cycle");
    a_err_unmapped: assert property
        (setup && (i_paddr > rtc_trim_pkg::OFS_PRESCALE
                   || i_paddr[1:0] != 2'h0) |=> o_pslverr)
        else $error("unmapped access without error");
    a_no_err_mapped: assert property (
        setup && i_paddr <= rtc_trim_pkg::OFS_PRESCALE
        && i_paddr[1:0] == 2'h0 |=> !o_pslverr)
        else $error("error on mapped access");
    a_err_needs_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_ctrl_upper_zero: assert property (
        rd && i_paddr == rtc_trim_pkg::OFS_TRIM_CTRL |-> o_prdata[31:4] == 0)
        else $error("trim control upper bits set");
    a_value_upper_zero: assert property (
        rd && i_paddr == rtc_trim_pkg::OFS_TRIM_VALUE |-> o_prdata[31:9] == 0)
        else $error("trim value upper bits set");
    a_irq_with_tick: assert property (o_irq_1hz |-> o_tick_1hz)
        else $error("irq apart from tick");
    a_tick_isolated: assert property (o_tick_1hz |=> !o_tick_1hz[*8])
        else $error("tick repeated too soon");

    // main scenarios reached
    c_irq: cover property (o_irq_1hz);
    c_err: cover property (o_pslverr);
    c_key_read: cover property (rd && i_paddr == rtc_trim_pkg::OFS_LOCK_KEY);
endmodule : rtc_trim_props

bind rtc_second_counter_trim rtc_trim_props #(.ADDR_W(ADDR_W)) u_props (.*);

`default_nettype wire

// >>> sim/rtc_second_counter_trim_tb_top.sv
/*
 * self-checking bench: register map, lock key, trimmed first second.
 * assumes the low-speed pin may toggle every core cycle to keep the run
 * short; the synchroniser sees each level for one core cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module rtc_second_counter_trim_tb_top;
    logic        i_core_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_low_speed_clock = 1'b0;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic        o_pready;
    logic        o_pslverr;
    logic [31:0] o_prdata;
    logic        o_tick_1hz;
    logic        o_irq_1hz;
    int          n_errors = 0;
    int          comparisons = 0;
    int          ls_edges = 0;
    logic        counting = 1'b0;
    logic [31:0] rdat;
    logic        rerr;

    rtc_second_counter_trim DUT (.*);

    // 100 ns core clock; pin clock toggles every rising edge for a short second
    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) i_low_speed_clock <= ~i_low_speed_clock;
    always @(posedge i_low_speed_clock) if (counting) ls_edges++;

    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    // one apb transfer; held until pready is seen at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 20) begin
            check(0, 1);
            test_done();
        end
    endtask : xfer

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        check(rdat, e);
        check(32'(rerr), 32'h0);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        repeat (8) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rd_chk(rtc_trim_pkg::OFS_LOCK_KEY, 32'h0000_00c1);
        rd_chk(rtc_trim_pkg::OFS_TRIM_CTRL, 32'h0);
        rd_chk(rtc_trim_pkg::OFS_TRIM_VALUE, 32'h0);
        // every period code with enable, bits 7:4 written as ones
        for (int c = 0; c < 5; c++) begin
            xfer(rtc_trim_pkg::OFS_TRIM_CTRL, 1'b1, 32'hf0 | (c << 1) | 1);
            rd_chk(rtc_trim_pkg::OFS_TRIM_CTRL, 32'((c << 1) | 1));
        end
        xfer(rtc_trim_pkg::OFS_TRIM_VALUE, 1'b1, 32'hffff_ffff);
        rd_chk(rtc_trim_pkg::OFS_TRIM_VALUE, 32'h1ff);
        // locked: writes dropped without an error
        xfer(rtc_trim_pkg::OFS_LOCK_KEY, 1'b1, 32'h5a);
        xfer(rtc_trim_pkg::OFS_TRIM_CTRL, 1'b1, 32'h0);
        check(32'(rerr), 32'h0);
        xfer(rtc_trim_pkg::OFS_TRIM_VALUE, 1'b1, 32'h0);
        rd_chk(rtc_trim_pkg::OFS_TRIM_CTRL, 32'h09);
        rd_chk(rtc_trim_pkg::OFS_TRIM_VALUE, 32'h1ff);
        xfer(8'h18, 1'b0, 32'h0);
        check(32'(rerr), 32'h1);
        // unlock, shortest second (-256) on every second
        xfer(rtc_trim_pkg::OFS_LOCK_KEY, 1'b1, 32'hc1);
        xfer(rtc_trim_pkg::OFS_TRIM_VALUE, 1'b1, 32'h100);
        xfer(rtc_trim_pkg::OFS_TRIM_CTRL, 1'b1, 32'h01);
        rd_chk(rtc_trim_pkg::OFS_TRIM_VALUE, 32'h100);
        xfer(rtc_trim_pkg::OFS_CNT_CTRL, 1'b1, 32'h1);
        n = 0;
        do begin
            xfer(rtc_trim_pkg::OFS_CNT_CTRL, 1'b0, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 20);
        check(rdat, 32'h0);
        xfer(rtc_trim_pkg::OFS_CNT_CTRL, 1'b1, 32'h2);
        counting = 1'b1;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_irq_1hz !== 1'b1 && n < 80000);
        counting = 1'b0;
        // sync delay lets the edge count drift by one either way
        check(32'(ls_edges >= 32511 && ls_edges <= 32513), 32'h1);
        check(32'(o_tick_1hz), 32'h1);
        repeat (2) @(posedge i_core_clk);
        rd_chk(rtc_trim_pkg::OFS_SECONDS, 32'h1);
        rd_chk(rtc_trim_pkg::OFS_SECONDS, 32'h1);
        // settings written soon after the interrupt, well inside the second
        xfer(rtc_trim_pkg::OFS_TRIM_VALUE, 1'b1, 32'h005);
        rd_chk(rtc_trim_pkg::OFS_TRIM_VALUE, 32'h005);
        test_done();
    end
endmodule : rtc_second_counter_trim_tb_top

`default_nettype wire
